// *** common/pcpsl_pkg.sv ***
package pcpsl_pkg;
  typedef enum logic [1:0] {
    PCPSL_RESP_OKAY = 2'h0,
    PCPSL_RESP_SLVERR = 2'h2
  } pcpsl_resp_t;
  typedef logic [3:0] pcpsl_err_t;
endpackage

// *** common/pcpsl_regs.svh ***
`ifndef PCPSL_REGS_SVH
`define PCPSL_REGS_SVH
// byte addresses of the two configuration words
`define PCPSL_DEV_STATUS_OFF 8'hC8
`define PCPSL_LINK_CAP_OFF 8'hCC
// block-local interrupt mask and load control registers
`define PCPSL_IRQ_MASK_OFF 8'hD8
`define PCPSL_LOAD_CTRL_OFF 8'hDC
// device status field positions
`define PCPSL_ST_CORR_BIT 16
`define PCPSL_ST_NONFATAL_BIT 17
`define PCPSL_ST_FATAL_BIT 18
`define PCPSL_ST_UNSUP_BIT 19
`define PCPSL_ST_AUX_BIT 20
`define PCPSL_ST_PEND_BIT 21
`define PCPSL_ST_ERR_LSB 16
`define PCPSL_ST_AUX_RST 1'h1
`define PCPSL_ST_PEND_VAL 1'h0
// link capability field defaults
`define PCPSL_CAP_SPEED_RST 4'h2
`define PCPSL_CAP_WIDTH_RST 6'h01
`define PCPSL_CAP_ASPM_RST 2'h3
`define PCPSL_CAP_L0S_RST 3'h3
`define PCPSL_CAP_L1_RST 3'h0
// timing of the exit latency ranges, for reference
`define PCPSL_L0S_EXIT_MIN_NS 256
`define PCPSL_L1_EXIT_MIN_US 16
`endif

// *** design/pcpsl_err_flags.sv ***
`timescale 1ns/100ps
// four sticky write-one-to-clear error flags
module pcpsl_err_flags
  import pcpsl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire pcpsl_err_t err_event,
  input wire pcpsl_err_t clear_mask,
  output pcpsl_err_t flags
);
  pcpsl_err_t flags_r;
  pcpsl_err_t flags_nxt;
  // set wins over clear; zero bits in the write leave flags alone
  assign flags_nxt = (flags_r & ~clear_mask) | err_event;
  assign flags = flags_r;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      flags_r <= 4'h0;
    end else begin
      flags_r <= flags_nxt;
    end
  end
endmodule

// *** design/pcpsl_port_regs.sv ***
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "pcpsl_regs.svh"
// Overview of operation
// - correctable error sets status bit 16; write one clears; resets zero
// - non-fatal error sets status bit 17; write one clears; resets zero
// - fatal error sets status bit 18; write one clears; resets zero
// - unsupported request sets status bit 19; write one clears; resets zero
// - flags log regardless of any reporting enable
// - status bit 20 read-only aux power present, resets to one
// - status bit 21 pending transactions always reads zero
// - capability 3:0 max speed read-only, resets to 5.0 Gb/s code 0010b
// - capability 9:4 max width read-only, resets to x1
// - capability 11:10 ASPM support read-only, resets to 11b
// - capability 14:12 L0s exit latency read-only, resets to 011b
// - capability 17:15 L1 exit latency read-only, resets to 000b
// - capability 18 clock PM resets to one upstream, zero downstream
// - capability 19 surprise down: one downstream, zero upstream
// - capability 20 link active reporting: zero on every port
// - capability 21 bandwidth notify: zero upstream, one downstream
// - capability 31:24 port number resets to port index
// - ASPM, latency and port number defaults reloadable by loader port
module pcpsl_port_regs
  import pcpsl_pkg::*;
#(
  parameter logic [1:0] PORT_INDEX = 2'h0
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic err_corr,
  input wire logic err_nonfatal,
  input wire logic err_fatal,
  input wire logic err_unsup,
  input wire logic load_valid,
  input wire logic [1:0] load_aspm,
  input wire logic [2:0] load_l0s_lat,
  input wire logic [2:0] load_l1_lat,
  input wire logic [7:0] load_port_num,
  input wire logic [1:0] load_clkpm_ds,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);
  // port 0 is the upstream port; ports 1 and 2 face downstream
  wire is_upstream = (PORT_INDEX == 2'h0);

  // AXI write holding and write/read response registers
  logic aw_held_r;
  logic [7:0] aw_addr_r;
  logic w_held_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  // reloadable capability fields
  logic [1:0] cap_aspm_r;
  logic [2:0] cap_l0s_r;
  logic [2:0] cap_l1_r;
  logic [7:0] cap_port_r;
  logic cap_clkpm_r;
  // interrupt mask, same layout as the status word
  logic [3:0] irq_mask_r;

  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] off);
    addr_is = (a[7:2] == off[7:2]);
  endfunction

  // accept address and data independently, either order
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held_r || aw_fire;
  wire w_have = w_held_r || w_fire;
  wire [7:0] wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
  wire [3:0] wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  wire wr_go = aw_have && w_have && !bvalid_r;

  // write decode
  wire wr_status = wr_go && addr_is(wr_addr, `PCPSL_DEV_STATUS_OFF);
  wire wr_mask = wr_go && addr_is(wr_addr, `PCPSL_IRQ_MASK_OFF);
  wire wr_known = addr_is(wr_addr, `PCPSL_DEV_STATUS_OFF) ||
                  addr_is(wr_addr, `PCPSL_LINK_CAP_OFF) ||
                  addr_is(wr_addr, `PCPSL_IRQ_MASK_OFF) ||
                  addr_is(wr_addr, `PCPSL_LOAD_CTRL_OFF);

  // w1c of the error flags lives in byte lane 2
  wire [3:0] err_clear = (wr_status && wr_strb[2]) ?
                         wr_data[`PCPSL_ST_UNSUP_BIT:`PCPSL_ST_ERR_LSB] :
                         4'h0;
  // raw detection drives the flags, no enable gating
  wire [3:0] err_event = {err_unsup, err_fatal, err_nonfatal,
                          err_corr};
  pcpsl_err_t err_flags;

  pcpsl_err_flags u_flags (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .err_event(err_event),
    .clear_mask(err_clear),
    .flags(err_flags)
  );

  // status word: error flags, aux power, pending transactions
  wire [31:0] status_word = {10'h000,
                             `PCPSL_ST_PEND_VAL,
                             `PCPSL_ST_AUX_RST,
                             err_flags,
                             16'h0000};

  // fields fixed per port role; bit 20 is zero everywhere
  wire cap_sdown = !is_upstream;
  wire cap_dll = 1'b0;
  wire cap_bwn = !is_upstream;
  wire [31:0] cap_word = {cap_port_r,
                          2'h0,
                          cap_bwn,
                          cap_dll,
                          cap_sdown,
                          cap_clkpm_r,
                          cap_l1_r,
                          cap_l0s_r,
                          cap_aspm_r,
                          `PCPSL_CAP_WIDTH_RST,
                          `PCPSL_CAP_SPEED_RST};

  // read decode
  assign s_axi_arready = !rvalid_r;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire rd_status = addr_is(s_axi_araddr, `PCPSL_DEV_STATUS_OFF);
  wire rd_cap = addr_is(s_axi_araddr, `PCPSL_LINK_CAP_OFF);
  wire rd_mask = addr_is(s_axi_araddr, `PCPSL_IRQ_MASK_OFF);
  wire rd_load = addr_is(s_axi_araddr, `PCPSL_LOAD_CTRL_OFF);
  wire rd_known = rd_status || rd_cap || rd_mask || rd_load;
  wire [31:0] rd_word = rd_status ? status_word :
                        rd_cap ? cap_word :
                        rd_mask ? {12'h000, irq_mask_r, 16'h0000} :
                        32'h0000_0000;

  // level interrupt from any unmasked sticky flag
  assign irq = |(err_flags & irq_mask_r);

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // address and data holding while the partner is late
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end else begin
        if (aw_fire) begin
          aw_held_r <= 1'b1;
          aw_addr_r <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_held_r <= 1'b1;
          w_data_r <= s_axi_wdata;
          w_strb_r <= s_axi_wstrb;
        end
      end
    end
  end

  // write response; unmapped addresses answer with slave error
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_known ? PCPSL_RESP_OKAY : PCPSL_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read response registered one cycle after the address
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'h0;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_known ? PCPSL_RESP_OKAY : PCPSL_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // interrupt mask lives in byte lane 2, aligned with the flags
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask_r <= 4'h0;
    end else if (wr_mask && wr_strb[2]) begin
      irq_mask_r <= wr_data[`PCPSL_ST_UNSUP_BIT:`PCPSL_ST_ERR_LSB];
    end
  end

  // loader overrides defaults; software writes never touch these
  // per-port defaults come straight out of reset, no settling window
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cap_aspm_r <= `PCPSL_CAP_ASPM_RST;
      cap_l0s_r <= `PCPSL_CAP_L0S_RST;
      cap_l1_r <= `PCPSL_CAP_L1_RST;
      cap_port_r <= {6'h00, PORT_INDEX};
      cap_clkpm_r <= (PORT_INDEX == 2'h0);
    end else if (load_valid) begin
      cap_aspm_r <= load_aspm;
      cap_l0s_r <= load_l0s_lat;
      cap_l1_r <= load_l1_lat;
      cap_port_r <= load_port_num;
      cap_clkpm_r <= is_upstream ? load_clkpm_ds[0] : load_clkpm_ds[1];
    end
  end
endmodule

// *** verif/pcpsl_port_regs_properties.sv ***
`timescale 1ns/100ps
`include "pcpsl_regs.svh"
// watches the register port from outside the block
module pcpsl_port_regs_chk #(
  parameter logic [1:0] PORT_INDEX = 2'h0
)(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic err_corr,
  input wire logic load_valid,
  input wire logic [7:0] load_port_num,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic rd_st_r;
  logic rd_cap_r;
  logic ds;
  assign ds = (PORT_INDEX != 2'h0);
  // remember which word the pending read answers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_st_r <= 1'b0;
      rd_cap_r <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_st_r <= (s_axi_araddr == `PCPSL_DEV_STATUS_OFF);
      rd_cap_r <= (s_axi_araddr == `PCPSL_LINK_CAP_OFF);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence ar_st;
    s_axi_arvalid && s_axi_arready
      && s_axi_araddr == `PCPSL_DEV_STATUS_OFF;
  endsequence
  sequence ar_cap;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `PCPSL_LINK_CAP_OFF;
  endsequence
  // no clear can land between the event and the read, except one using write data already held
  sequence err_seen;
    err_corr ##1 !(s_axi_wvalid || s_axi_bvalid) ##1 ar_st;
  endsequence
  sequence load_seen;
    load_valid ##1 !load_valid ##1 ar_cap;
  endsequence
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  AST_B_ANSWER: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer late");
  AST_ST_FIXED: assert property (
    s_axi_rvalid && rd_st_r |-> s_axi_rdata[31:20] == 12'h001)
    else $error("status fixed bits wrong");
  AST_CAP_FIXED: assert property (
    s_axi_rvalid && rd_cap_r |-> s_axi_rdata[9:0] == 10'h012
    && s_axi_rdata[23:19] == {2'h0, ds, 1'h0, ds})
    else $error("capability fixed bits wrong");
  AST_ERR_SET: assert property (err_seen |=> s_axi_rdata[16])
    else $error("error flag not set");
  AST_CAP_LOAD: assert property (load_seen |=>
    s_axi_rdata[31:24] == $past(load_port_num, 3))
    else $error("port number not loaded");
endmodule
bind pcpsl_port_regs pcpsl_port_regs_chk #(.PORT_INDEX(PORT_INDEX))
  i_pcpsl_port_regs_chk (.*);

// *** verif/pcpsl_port_regs_tb.sv ***
`timescale 1ns/100ps
`include "pcpsl_regs.svh"
module pcpsl_port_regs_tb;
  logic sys_clk, resetn, load_valid, irq;
  logic [3:0] err_in;
  logic [17:0] ld;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int errors, n_compared;
  // port 2: a downstream port, so surprise down and bandwidth notify read one, clock PM zero
  pcpsl_port_regs #(.PORT_INDEX(2'h2)) i_pcpsl_port_regs (
    .sys_clk(sys_clk), .resetn(resetn), .err_corr(err_in[0]),
    .err_nonfatal(err_in[1]), .err_fatal(err_in[2]),
    .err_unsup(err_in[3]), .load_valid(load_valid),
    .load_aspm(ld[1:0]), .load_l0s_lat(ld[4:2]), .load_l1_lat(ld[7:5]),
    .load_port_num(ld[15:8]), .load_clkpm_ds(ld[17:16]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one write; each channel is released at its own handshake
  // handshakes are judged mid-cycle, where the ready lines are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    logic aw_ok, w_ok, b_ok;
    logic [1:0] resp;
    n = 0;
    b_ok = 1'b0;
    resp = 2'h0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = (bvalid === 1'b1);
      resp = bresp;
      @(posedge sys_clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      n++;
    end while (!b_ok && n < 40);
    bready <= 1'b0;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    chk("bvalid", 32'h1, {31'h0, b_ok});
    chk("bresp", {30'h0, er}, {30'h0, resp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int n;
    logic ar_ok, r_ok;
    logic [31:0] data;
    logic [1:0] resp;
    n = 0;
    r_ok = 1'b0;
    data = 32'h0000_0000;
    resp = 2'h0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ar_ok = arvalid && arready;
      r_ok = (rvalid === 1'b1);
      data = rdata;
      resp = rresp;
      @(posedge sys_clk);
      if (ar_ok) arvalid <= 1'b0;
      n++;
    end while (!r_ok && n < 40);
    rready <= 1'b0;
    arvalid <= 1'b0;
    chk("rvalid", 32'h1, {31'h0, r_ok});
    chk("rdata", e, data);
    chk("rresp", {30'h0, er}, {30'h0, resp});
  endtask
  // one-cycle error event
  task automatic pulse(input int i);
    @(posedge sys_clk);
    err_in[i] <= 1'b1;
    @(posedge sys_clk);
    err_in <= 4'h0;
  endtask
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, far beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("ERROR watchdog expired");
    end_of_test;
  end
  initial begin
    {sys_clk, resetn, load_valid, err_in, ld} = '0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, errors, n_compared} = '0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(`PCPSL_DEV_STATUS_OFF, 32'h00100000, 2'h0);
    rd(`PCPSL_LINK_CAP_OFF, 32'h02283C12, 2'h0);
    wr(`PCPSL_LINK_CAP_OFF, 32'hFFFFFFFF, 2'h0);
    rd(`PCPSL_LINK_CAP_OFF, 32'h02283C12, 2'h0);
    rd(`PCPSL_LINK_CAP_OFF, 32'h02283C12, 2'h0);
    // each flag: set, survives a zero write, cleared by a one
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      rd(`PCPSL_DEV_STATUS_OFF, (32'h00010000 << i) | 32'h00100000,
         2'h0);
      wr(`PCPSL_DEV_STATUS_OFF, 32'h0, 2'h0);
      rd(`PCPSL_DEV_STATUS_OFF, (32'h00010000 << i) | 32'h00100000,
         2'h0);
      wr(`PCPSL_DEV_STATUS_OFF, 32'h00010000 << i, 2'h0);
      rd(`PCPSL_DEV_STATUS_OFF, 32'h00100000, 2'h0);
    end
    // an event held across the clearing write wins
    @(posedge sys_clk);
    err_in[0] <= 1'b1;
    wr(`PCPSL_DEV_STATUS_OFF, 32'h00010000, 2'h0);
    err_in <= 4'h0;
    rd(`PCPSL_DEV_STATUS_OFF, 32'h00110000, 2'h0);
    wr(`PCPSL_DEV_STATUS_OFF, 32'h000F0000, 2'h0);
    // interrupt: unmasked raises, clear drops, masked stays low
    wr(`PCPSL_IRQ_MASK_OFF, 32'h000F0000, 2'h0);
    rd(`PCPSL_IRQ_MASK_OFF, 32'h000F0000, 2'h0);
    pulse(2);
    @(posedge sys_clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`PCPSL_DEV_STATUS_OFF, 32'h00040000, 2'h0);
    @(posedge sys_clk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(`PCPSL_IRQ_MASK_OFF, 32'h0, 2'h0);
    pulse(3);
    @(posedge sys_clk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(`PCPSL_DEV_STATUS_OFF, 32'h00180000, 2'h0);
    // unmapped and reserved places
    rd(8'h10, 32'h0, 2'h2);
    wr(8'h10, 32'hFFFFFFFF, 2'h2);
    rd(`PCPSL_LOAD_CTRL_OFF, 32'h0, 2'h0);
    // loader replaces the reloadable defaults
    @(posedge sys_clk);
    load_valid <= 1'b1;
    ld <= {2'h2, 8'h5A, 3'h2, 3'h5, 2'h1};
    @(posedge sys_clk);
    load_valid <= 1'b0;
    rd(`PCPSL_LINK_CAP_OFF, 32'h5A2D5412, 2'h0);
    end_of_test;
  end
endmodule
